// File: logic/bbc_pkg.sv
package bbc_pkg;
  // ----------------------------------------------------------------
  // opcode patterns
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_BIT_TEST_SKIP_CLEAR = 4'hB;
  localparam logic [3:0] OP_BIT_TEST_SKIP_SET   = 4'hA;
  localparam logic [3:0] OP_BIT_INVERT          = 4'h7;
  localparam logic [3:0] OP_BRANCH_GROUP        = 4'hE;
  localparam logic [3:0] CC_OVERFLOW            = 4'h4;
  localparam logic [3:0] CC_ZERO                = 4'h0;
  localparam logic [6:0] OP_CALL_HI             = 7'h76;
  localparam logic [3:0] OP_SECOND_WORD         = 4'hF;
  localparam logic [6:0] OP_REGISTER_ZERO       = 7'h35;
  localparam logic [5:0] OP_REGISTER_INVERT     = 6'h07;
  localparam logic [6:0] OP_COMPARE_EQUAL       = 7'h31;
  localparam logic [15:0] OP_WATCHDOG_RESTART   = 16'h0004;
  localparam logic [15:0] OP_NOP                = 16'h0000;
  // ----------------------------------------------------------------
  // widths, flags, register bus map
  // ----------------------------------------------------------------
  localparam int PC_W   = 21;
  localparam int DADDR_W = 12;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] CALL_RET = 21'h000004;
  localparam logic [3:0] ACCESS_BANK = 4'h0;
  localparam int FLAG_N = 4;
  localparam int FLAG_OV = 3;
  localparam int FLAG_Z = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] WB_PC_LO    = 4'h0;
  localparam logic [3:0] WB_WORK     = 4'h4;
  localparam logic [3:0] WB_FLAGS    = 4'h8;
  localparam logic [3:0] WB_BANK     = 4'hC;
endpackage : bbc_pkg

// File: logic/bbc_decode.sv
// combinational decode of one 16-bit instruction word
module bbc_decode
  import bbc_pkg::*;
(
  input  wire logic [15:0] instr,
  output logic             is_btsc,
  output logic             is_btss,
  output logic             is_btg,
  output logic             is_bov,
  output logic             is_bz,
  output logic             is_call,
  output logic             is_clr,
  output logic             is_wdt,
  output logic             is_com,
  output logic             is_cpeq,
  output logic             is_two_word
);
  // ----------------------------------------------------------------
  // pattern match
  // ----------------------------------------------------------------
  always_comb begin
    is_btsc     = instr[15:12] == OP_BIT_TEST_SKIP_CLEAR; // RULE_01
    is_btss     = instr[15:12] == OP_BIT_TEST_SKIP_SET;   // RULE_02
    is_btg      = instr[15:12] == OP_BIT_INVERT;          // RULE_04
    is_bov      = instr[15:12] == OP_BRANCH_GROUP && instr[11:8] == CC_OVERFLOW; // RULE_05
    is_bz       = instr[15:12] == OP_BRANCH_GROUP && instr[11:8] == CC_ZERO;     // RULE_05
    is_call     = instr[15:9] == OP_CALL_HI;              // RULE_07
    is_clr      = instr[15:9] == OP_REGISTER_ZERO;        // RULE_10
    is_wdt      = instr == OP_WATCHDOG_RESTART;           // RULE_11
    is_com      = instr[15:10] == OP_REGISTER_INVERT;     // RULE_12
    is_cpeq     = instr[15:9] == OP_COMPARE_EQUAL;        // RULE_13
    is_two_word = is_call;
  end
endmodule // bbc_decode

// File: logic/bbc_exec.sv
// Summary of operation
// [RULE_01] bit test skip clear: skip next word when addressed bit is zero
// [RULE_02] bit test skip set: skip next word when addressed bit is one
// [RULE_03] skip costs one extra cycle, two if the skipped word is two-word
// [RULE_04] bit invert flips one bit by read-modify-write, flags untouched
// [RULE_05] branch on overflow or zero adds twice signed offset when taken
// [RULE_06] taken branch target is branch address plus two plus 2n, then nop cycle
// [RULE_07] call pushes call address plus four to return stack top
// [RULE_08] call with shadow bit copies work, flags and bank into shadows
// [RULE_09] call target is 20 bits from both words, written to pc[20:1]
// [RULE_10] register zero writes zero and sets the zero flag
// [RULE_11] watchdog restart clears counter and postscaler, sets timeout/powerdown
// [RULE_12] register invert complements, updates N and Z, d selects destination
// [RULE_13] compare equal skips on equality, no flag changes
// [RULE_14] access bit 0 uses access bank, 1 uses bank select plus file
// [RULE_15] skip suppresses execute of fetched words while pc keeps counting
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
module bbc_exec
  import bbc_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [15:0]            instr_word,
  input  wire logic                   instr_valid,
  output logic                        instr_ready,
  output logic [bbc_pkg::PC_W-1:0]    pc_out,
  output logic                        watchdog_restart,
  output logic                        timeout_flag,
  output logic                        powerdown_flag,
  output logic [bbc_pkg::PC_W-1:0]    return_stack_top,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [3:0]             wb_adr_i,
  input  wire logic [31:0]            wb_dat_i,
  input  wire logic [3:0]             wb_sel_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o
);
  import bbc_pkg::*;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BBC_EXEC  = 2'b00,
    BBC_FLUSH = 2'b01,
    BBC_CALL2 = 2'b10
  } bbc_state_e;

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  logic is_btsc, is_btss, is_btg, is_bov, is_bz, is_call, is_clr, is_wdt;
  logic is_com, is_cpeq, is_two_word;

  // pattern match of the word on the fetch port
  bbc_decode u_dec (
    .instr       (instr_word),
    .is_btsc     (is_btsc),
    .is_btss     (is_btss),
    .is_btg      (is_btg),
    .is_bov      (is_bov),
    .is_bz       (is_bz),
    .is_call     (is_call),
    .is_clr      (is_clr),
    .is_wdt      (is_wdt),
    .is_com      (is_com),
    .is_cpeq     (is_cpeq),
    .is_two_word (is_two_word)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bbc_state_e         state_reg, state_next;
  logic [PC_W-1:0]    pc_reg, pc_next;
  logic [PC_W-1:0]    tos_reg, tos_next;
  logic [7:0]         work_reg, work_next;
  logic [7:0]         flags_reg, flags_next;
  logic [3:0]         bank_reg, bank_next;
  // shadow copies, written only by a call with its shadow bit set
  logic [7:0]         work_shadow, work_shadow_next;
  logic [7:0]         flags_shadow, flags_shadow_next;
  logic [3:0]         bank_shadow, bank_shadow_next;
  logic               to_reg, to_next, pd_reg, pd_next, wdt_reg, wdt_next;
  logic [1:0]         flush_reg, flush_next;
  logic [7:0]         call_lo_reg, call_lo_next;
  logic               shadow_sel_reg, shadow_sel_next;
  logic [7:0]         mem [DEPTH];
  logic               mem_we;
  logic [7:0]         mem_wdata;
  logic [31:0]        rdata_reg, rdata_next;
  logic               ack_reg, ack_next;

  // ----------------------------------------------------------------
  // operand fetch
  // ----------------------------------------------------------------
  logic [DADDR_W-1:0] daddr;
  logic [7:0]         fval, bitmask, comp;
  logic [$clog2(DEPTH)-1:0] idx;
  logic [PC_W-1:0]    br_off;
  // file address: access bank, or bank select plus file field
  assign daddr   = instr_word[8] ? {bank_reg, instr_word[7:0]}
                                 : {ACCESS_BANK, instr_word[7:0]}; // RULE_14
  // operand read from the flip-flop data memory
  assign idx     = daddr[$clog2(DEPTH)-1:0];
  assign fval    = mem[idx];
  // bit select mask and complemented operand
  assign bitmask = 8'h01 << instr_word[11:9];
  assign comp    = ~fval;
  // signed offset, doubled and sign extended to the pc width
  assign br_off  = PC_W'({{(PC_W-9){instr_word[7]}}, instr_word[7:0], 1'b0});
  // one word taken every clock, no back pressure
  assign instr_ready = 1'b1;

  // ----------------------------------------------------------------
  // execute next-state logic
  // ----------------------------------------------------------------
  // next values for one instruction cycle; flush and call2 absorb extra words
  always_comb begin
    state_next        = state_reg;
    pc_next           = pc_reg;
    tos_next          = tos_reg;
    work_next         = work_reg;
    flags_next        = flags_reg;
    bank_next         = bank_reg;
    work_shadow_next  = work_shadow;
    flags_shadow_next = flags_shadow;
    bank_shadow_next  = bank_shadow;
    to_next           = to_reg;
    pd_next           = pd_reg;
    wdt_next          = 1'b0;
    flush_next        = flush_reg;
    call_lo_next      = call_lo_reg;
    shadow_sel_next   = shadow_sel_reg;
    mem_we            = 1'b0;
    mem_wdata         = fval;
    if (instr_valid) begin
      unique case (state_reg)
        BBC_EXEC: begin
          pc_next = pc_reg + PC_STEP;
          if ((is_btsc && (fval & bitmask) == REG_RESET) ||                 // RULE_01
              (is_btss && (fval & bitmask) != REG_RESET) ||                 // RULE_02
              (is_cpeq && fval == work_reg)) begin                          // RULE_13
            state_next = BBC_FLUSH;
            flush_next = 2'd1;                                              // RULE_03
          end else if (is_btg) begin
            mem_we    = 1'b1;
            mem_wdata = fval ^ bitmask;                                     // RULE_04
          end else if ((is_bov && flags_reg[FLAG_OV]) || (is_bz && flags_reg[FLAG_Z])) begin
            pc_next    = pc_reg + PC_STEP + br_off;                         // RULE_05 RULE_06
            state_next = BBC_FLUSH;
            flush_next = 2'd1;                                              // RULE_06
          end else if (is_call) begin
            tos_next        = pc_reg + CALL_RET;                            // RULE_07
            call_lo_next    = instr_word[7:0];
            shadow_sel_next = instr_word[8];
            state_next      = BBC_CALL2;
            if (instr_word[8]) begin
              work_shadow_next  = work_reg;                                 // RULE_08
              flags_shadow_next = flags_reg;
              bank_shadow_next  = bank_reg;
            end
          end else if (is_clr) begin
            mem_we            = 1'b1;
            mem_wdata         = REG_RESET;                                  // RULE_10
            flags_next[FLAG_Z] = 1'b1;
          end else if (is_wdt) begin
            wdt_next = 1'b1;                                                // RULE_11
            to_next  = 1'b1;
            pd_next  = 1'b1;
          end else if (is_com) begin
            flags_next[FLAG_N] = comp[7];                                   // RULE_12
            flags_next[FLAG_Z] = comp == REG_RESET;
            if (instr_word[9]) begin
              mem_we    = 1'b1;
              mem_wdata = comp;
            end else begin
              work_next = comp;
            end
          end
        end
        BBC_FLUSH: begin
          pc_next = pc_reg + PC_STEP;                                       // RULE_15
          // a flushed two-word op pulls its second word into the flush too
          if (flush_reg == 2'd1 && instr_word[15:12] != OP_SECOND_WORD && is_two_word) begin
            flush_next = 2'd2;                                              // RULE_03
          end else begin
            flush_next = 2'd0;
            state_next = BBC_EXEC;
          end
        end
        BBC_CALL2: begin
          // second word supplies the upper target bits
          pc_next    = {instr_word[11:0], call_lo_reg, 1'b0};               // RULE_09
          state_next = BBC_FLUSH;
          flush_next = 2'd2;
        end
        default: state_next = BBC_EXEC;
      endcase
    end
    // bus writes land only while idle in the execute state
    if (ack_next && wb_we_i && wb_sel_i[0] && state_reg == BBC_EXEC
        && !instr_valid) begin
      unique case (wb_adr_i)
        WB_WORK:  work_next  = wb_dat_i[7:0];
        WB_FLAGS: flags_next = wb_dat_i[7:0];
        WB_BANK:  bank_next  = wb_dat_i[3:0];
        default:  ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  // ack one cycle after the take, read data registered beside it
  always_comb begin
    ack_next   = wb_cyc_i && wb_stb_i && !ack_reg;
    rdata_next = 32'h00000000;
    unique case (wb_adr_i)
      WB_PC_LO: rdata_next = 32'(pc_reg);
      WB_WORK:  rdata_next = {4'h0, bank_shadow, flags_shadow, work_shadow, work_reg}; // RULE_08
      WB_FLAGS: rdata_next = {22'h000000, pd_reg, to_reg, flags_reg};
      WB_BANK:  rdata_next = {28'h0000000, bank_reg};
      default:  rdata_next = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // every state register on the one asynchronous reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg      <= BBC_EXEC;
      pc_reg         <= '0;
      tos_reg        <= '0;
      work_reg       <= REG_RESET;
      flags_reg      <= REG_RESET;
      bank_reg       <= ACCESS_BANK;
      work_shadow    <= REG_RESET;
      flags_shadow   <= REG_RESET;
      bank_shadow    <= ACCESS_BANK;
      to_reg         <= 1'b1;
      pd_reg         <= 1'b1;
      wdt_reg        <= 1'b0;
      flush_reg      <= 2'd0;
      call_lo_reg    <= REG_RESET;
      shadow_sel_reg <= 1'b0;
      rdata_reg      <= 32'h00000000;
      ack_reg        <= 1'b0;
    end else begin
      state_reg      <= state_next;
      pc_reg         <= pc_next;
      tos_reg        <= tos_next;
      work_reg       <= work_next;
      flags_reg      <= flags_next;
      bank_reg       <= bank_next;
      work_shadow    <= work_shadow_next;
      flags_shadow   <= flags_shadow_next;
      bank_shadow    <= bank_shadow_next;
      to_reg         <= to_next;
      pd_reg         <= pd_next;
      wdt_reg        <= wdt_next;
      flush_reg      <= flush_next;
      call_lo_reg    <= call_lo_next;
      shadow_sel_reg <= shadow_sel_next;
      rdata_reg      <= rdata_next;
      ack_reg        <= ack_next;
    end
  end

  // ----------------------------------------------------------------
  // data memory
  // ----------------------------------------------------------------
  // data memory slice, one entry per index
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_mem
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mem[gi] <= REG_RESET;
        end else if (mem_we && idx == gi) begin
          mem[gi] <= mem_wdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // registered values straight to the pins
  assign pc_out           = pc_reg;
  assign return_stack_top = tos_reg;
  assign timeout_flag     = to_reg;
  assign powerdown_flag   = pd_reg;
  assign watchdog_restart = wdt_reg; // RULE_11
  assign wb_dat_o         = rdata_reg;
  assign wb_ack_o         = ack_reg;
endmodule // bbc_exec

// File: verification/bbc_exec_chk.sv
module bbc_exec_chk
  import bbc_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic [15:0]              instr_word,
  input wire logic                     instr_valid,
  input wire logic [bbc_pkg::PC_W-1:0] pc_out,
  input wire logic                     watchdog_restart,
  input wire logic                     timeout_flag,
  input wire logic                     powerdown_flag,
  input wire logic [bbc_pkg::PC_W-1:0] return_stack_top,
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // named steps
  // ----------------------------------------------------------------
  sequence s_call_first;
    instr_valid && instr_word[15:9] == OP_CALL_HI;
  endsequence
  sequence s_call_second;
    instr_valid && instr_word[15:12] == OP_SECOND_WORD && $changed(return_stack_top);
  endsequence
  sequence s_plain_op;
    instr_valid && instr_word[15:12] inside {4'h0, 4'h1, 4'h6, 4'h7, 4'hA, 4'hB}
      && $past(instr_word[15:12]) != 4'hE && $past(instr_word[15:12], 2) != 4'hE;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_pc_even: assert property (pc_out[0] == 1'b0)
    else $error("program counter bit 0 set");
  a_pc_hold: assert property (!instr_valid |=> $stable(pc_out))
    else $error("program counter moved without an instruction");
  a_pc_step_plain: assert property (s_plain_op |=> pc_out == $past(pc_out) + PC_STEP)
    else $error("program counter did not step by two");
  a_call_push: assert property ($changed(return_stack_top) |->
      $past(instr_valid) && $past(instr_word[15:9]) == OP_CALL_HI
      && return_stack_top == $past(pc_out) + CALL_RET)
    else $error("return stack top wrong or changed without call");
  a_call_target: assert property (s_call_first ##1 s_call_second |=>
      pc_out == {$past(instr_word[11:0]), $past(instr_word[7:0], 2), 1'b0})
    else $error("call target not loaded");
  a_wdt_cause: assert property (watchdog_restart |->
      $past(instr_valid) && $past(instr_word) == OP_WATCHDOG_RESTART)
    else $error("watchdog restart without its opcode");
  a_wdt_flags: assert property (watchdog_restart |-> timeout_flag && powerdown_flag)
    else $error("timeout or powerdown flag low on restart");
endmodule // bbc_exec_chk

// File: verification/testbench.sv
module testbench
  import bbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk, rst, instr_valid, instr_ready, wb_cyc_i, wb_stb_i, wb_we_i;
  logic                watchdog_restart, timeout_flag, powerdown_flag, wb_ack_o;
  logic [15:0]         instr_word;
  logic [3:0]          wb_adr_i, wb_sel_i;
  logic [31:0]         wb_dat_i, wb_dat_o, rd;
  logic [PC_W-1:0]     pc_out, return_stack_top, p;
  int                  fails = 0, checks = 0, cycles = 0, pulses = 0;

  bbc_exec #(.DEPTH(512)) uut (.clk(clk), .rst(rst), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .pc_out(pc_out),
    .watchdog_restart(watchdog_restart), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .return_stack_top(return_stack_top),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  // ----------------------------------------------------------------
  // clock, pulse counter, hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (watchdog_restart === 1'b1) pulses++;
    cycles++;
    if (cycles == 5000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic bus cycle, held until ack is sampled high at a rising edge
  task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic exec(input logic [15:0] w);
    instr_valid <= 1'b1;
    instr_word  <= w;
    @(posedge clk);
  endtask

  task automatic idle();
    instr_valid <= 1'b0;
    instr_word  <= OP_NOP;
    repeat (2) @(posedge clk);
  endtask

  task automatic op_chk(input logic [15:0] w, input logic [3:0] adr, input logic [31:0] e);
    exec(w);
    idle();
    wb_cycle(1'b0, adr, 32'h0);
    check(rd, e);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    wb_cycle(1'b1, WB_PC_LO, 32'h40);
    wb_cycle(1'b0, WB_PC_LO, 32'h0);
    check(rd, 32'h0);
    wb_cycle(1'b0, WB_FLAGS, 32'h0);
    check(rd, 32'h300);
    wb_cycle(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    check({31'h0, instr_ready}, 32'h1);
  endtask

  task automatic t_alu();
    op_chk(16'h1C05, WB_WORK, 32'hFF);
    op_chk(16'h1C05, WB_FLAGS, 32'h310);
    exec(16'h1E05);
    op_chk(16'h1C05, WB_WORK, 32'h00);
    wb_cycle(1'b1, WB_FLAGS, 32'h0);
    op_chk(16'h6A05, WB_FLAGS, 32'h304);
    op_chk(16'h1C05, WB_WORK, 32'hFF);
    wb_cycle(1'b1, WB_FLAGS, 32'h18);
    op_chk(16'h7605, WB_FLAGS, 32'h318);
    op_chk(16'h1C05, WB_WORK, 32'hF7);
  endtask

  task automatic skip_chk(input logic [15:0] w, input logic skip);
    int n;
    n = pulses;
    p = pc_out;
    exec(w);
    exec(OP_WATCHDOG_RESTART);
    idle();
    check(pulses - n, {31'h0, !skip});
    check({11'h0, pc_out}, {11'h0, p + PC_STEP + PC_STEP});
    check({30'h0, timeout_flag, powerdown_flag}, 32'h3);
  endtask

  task automatic t_skip();
    skip_chk(16'hB605, 1'b0);
    skip_chk(16'hB405, 1'b1);
    skip_chk(16'hA605, 1'b1);
    skip_chk(16'hA405, 1'b0);
    wb_cycle(1'b1, WB_FLAGS, 32'h0);
    wb_cycle(1'b1, WB_WORK, 32'h08);
    skip_chk(16'h6205, 1'b1);
    wb_cycle(1'b1, WB_WORK, 32'h09);
    skip_chk(16'h6205, 1'b0);
    wb_cycle(1'b0, WB_FLAGS, 32'h0);
    check(rd, 32'h300);
  endtask

  task automatic t_skip_two_word();
    int n;
    n = pulses;
    p = return_stack_top;
    wb_cycle(1'b0, WB_PC_LO, 32'h0);
    exec(16'hA605);
    exec(16'hEC55);
    exec(16'hF001);
    exec(OP_WATCHDOG_RESTART);
    idle();
    check(pulses - n, 32'h1);
    check({11'h0, pc_out}, rd + 32'h8);
    check({11'h0, return_stack_top}, {11'h0, p});
  endtask

  task automatic t_bank();
    wb_cycle(1'b1, WB_BANK, 32'h1);
    exec(16'h1F05);
    op_chk(16'h1C05, WB_WORK, 32'hF7);
    op_chk(16'h1D05, WB_WORK, 32'h00);
  endtask

  task automatic t_branch();
    logic [15:0] ops [4];
    logic [31:0] fl [4];
    logic [PC_W-1:0] e;
    ops = '{16'hE003, 16'hE0FE, 16'hE4FE, 16'hE403};
    fl = '{32'h04, 32'h00, 32'h08, 32'h04};
    for (int i = 0; i < 4; i++) begin
      wb_cycle(1'b1, WB_FLAGS, fl[i]);
      p = pc_out;
      e = p + PC_STEP;
      if (i % 2 == 0) e = e + {{12{ops[i][7]}}, ops[i][7:0], 1'b0};
      exec(ops[i]);
      idle();
      check({11'h0, pc_out}, {11'h0, e});
      exec(OP_NOP);
      idle();
    end
  endtask

  task automatic call_chk(input logic [15:0] w1, input logic [15:0] w2);
    p = pc_out;
    exec(w1);
    exec(w2);
    idle();
    check({11'h0, return_stack_top}, {11'h0, p + CALL_RET});
    check({11'h0, pc_out}, {11'h0, w2[11:0], w1[7:0], 1'b0});
    exec(OP_NOP);
    idle();
  endtask

  initial begin
    {instr_valid, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
    rst = 1'b1;
    instr_word = OP_NOP;
    wb_adr_i = 4'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_alu();
    t_skip();
    t_skip_two_word();
    t_bank();
    t_branch();
    wb_cycle(1'b1, WB_WORK, 32'h5A);
    call_chk(16'hED45, 16'hF123);
    wb_cycle(1'b0, WB_WORK, 32'h0);
    check(rd, 32'h01045A5A);
    wb_cycle(1'b1, WB_WORK, 32'hA5);
    call_chk(16'hEC10, 16'hF000);
    wb_cycle(1'b0, WB_WORK, 32'h0);
    check(rd, 32'h01045AA5);
    tally_and_finish();
  end
endmodule // testbench

bind bbc_exec bbc_exec_chk #(.DEPTH(DEPTH)) u_chk (.clk(clk), .rst(rst),
  .instr_word(instr_word), .instr_valid(instr_valid), .pc_out(pc_out),
  .watchdog_restart(watchdog_restart), .timeout_flag(timeout_flag),
  .powerdown_flag(powerdown_flag), .return_stack_top(return_stack_top),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
